//--- core/acsr_map.vh
// Register map, field positions and reset values of the channel select and readout block.
// Assumes a 32-bit Wishbone slave; byte address is four times the register index.
`ifndef ACSR_MAP_VH
`define ACSR_MAP_VH

// Register indices (byte address = index * 4)
`define ACSR_IDX_STATUS 3'h0
`define ACSR_IDX_MODE 3'h1
`define ACSR_IDX_CONFIG 3'h2
`define ACSR_IDX_RESULT 3'h3
`define ACSR_IDX_IDENT 3'h4
`define ACSR_IDX_IRQ_STATUS 3'h5
`define ACSR_IDX_IRQ_MASK 3'h6

// Mode register fields
`define ACSR_MODE_APPEND 0

// Configuration register fields
`define ACSR_CFG_CH_LSB 0
`define ACSR_CFG_CH_MSB 7
`define ACSR_CFG_TEMP 8
`define ACSR_CFG_SHORT 9
`define ACSR_CFG_PSEUDO 10
`define ACSR_CFG_GAIN_LSB 12
`define ACSR_CFG_GAIN_MSB 14
`define ACSR_CFG_RESET 32'h00000001

// Status register fields
`define ACSR_ST_IND_LSB 0
`define ACSR_ST_IND_MSB 3
`define ACSR_ST_GAIN_ERR 6
`define ACSR_ST_NOT_READY 7

// Interrupt status and mask bits
`define ACSR_IRQ_NEW_RESULT 0
`define ACSR_IRQ_READ_DONE 1
`define ACSR_IRQ_BITS 2

// Result register
`define ACSR_RESULT_RESET 24'h000000
`define ACSR_RESULT_BITS 24
`define ACSR_APPEND_BITS 32

// Sequencer slots: channel enables 0..7, then temperature, then shorted input
`define ACSR_SLOT_TEMP 4'h8
`define ACSR_SLOT_SHORT 4'h9
`define ACSR_SLOTS 10

// Channel indicator codes
`define ACSR_IND_TEMP 4'h8
`define ACSR_IND_SHORT 4'h9

// Analog input codes for the front-end mux
`define ACSR_IN_COMMON 4'h0
`define ACSR_IN_TEMP 4'hE
`define ACSR_IN_NONE 4'hF

// Gain codes
`define ACSR_GAIN_X1 3'h0
`define ACSR_GAIN_R1 3'h1
`define ACSR_GAIN_R2 3'h2

`endif

//--- core/acsr_chan_decode.v
// Combinational channel decode: sequencer slot and input mode to mux, indicator and pair.
// Assumes slot is 0..9 as defined in acsr_map.vh; other slots decode as no input.
`timescale 1ns/1ps
`default_nettype none
`include "acsr_map.vh"

module acsr_chan_decode (
    input wire [3:0] slot,
    input wire pseudo,
    output reg [3:0] indicator,
    output reg [3:0] pos_in,
    output reg [3:0] neg_in,
    output reg [2:0] cal_pair,
    output reg cal_pair_valid
);
    always @* begin
        indicator = slot;
        pos_in = `ACSR_IN_NONE;
        neg_in = `ACSR_IN_NONE;
        cal_pair = 3'h0;
        cal_pair_valid = 1'b0;
        if (slot < 4'h8) begin
            cal_pair_valid = 1'b1;
            if (pseudo) begin
                pos_in = slot + 4'h1;
                neg_in = `ACSR_IN_COMMON;
                cal_pair = slot[2] ? 3'h4 : {1'b0, slot[1:0]};
            end else begin
                pos_in = {slot[1:0], 1'b0} + 4'h1;
                neg_in = {slot[1:0], 1'b0} + 4'h2;
                cal_pair = {1'b0, slot[1:0]};
            end
        end else if (slot == `ACSR_SLOT_TEMP) begin
            indicator = `ACSR_IND_TEMP;
            pos_in = `ACSR_IN_TEMP;
            neg_in = `ACSR_IN_TEMP;
        end else if (slot == `ACSR_SLOT_SHORT) begin
            indicator = `ACSR_IND_SHORT;
            cal_pair_valid = 1'b1;
            pos_in = pseudo ? `ACSR_IN_COMMON : 4'h2;
            neg_in = pseudo ? `ACSR_IN_COMMON : 4'h2;
        end
    end
endmodule // acsr_chan_decode

`default_nettype wire

//--- core/acsr_top.v
// Channel sequencer, result register, status, identification and serial readout.
// Assumes a classic Wishbone master on clk, conversion words from the modulator on clk,
// and a host serial clock and select that are asynchronous and sampled here.
`timescale 1ns/1ps
`default_nettype none
`include "acsr_map.vh"

module acsr_top #(
    parameter [7:0] ID_VALUE = 8'hA5 // Arbitrary identification value
) (
    input wire clk,
    input wire arst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire conv_valid,
    input wire [23:0] conv_data,
    input wire ser_clk,
    input wire ser_cs_n,
    output reg ser_dout,
    output reg rdy_n,
    output reg irq,
    output reg [3:0] ain_pos,
    output reg [3:0] ain_neg,
    output reg [2:0] cal_pair,
    output reg cal_pair_valid,
    output reg [3:0] channel_indicator,
    output reg [2:0] gain_log2
);
    // Byte-lane merge for register writes
    function [31:0] merge_sel;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        integer b;
        begin
            merge_sel = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b])
                    merge_sel[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
    endfunction

    // Next enabled slot above cur, else the lowest enabled one
    function [3:0] next_slot;
        input [9:0] en;
        input [3:0] cur;
        integer k;
        reg found;
        begin
            found = 1'b0;
            next_slot = cur;
            for (k = `ACSR_SLOTS - 1; k >= 0; k = k - 1) begin
                if (en[k] && (k > cur)) begin
                    next_slot = k[3:0];
                    found = 1'b1;
                end
            end
            if (!found) begin
                for (k = `ACSR_SLOTS - 1; k >= 0; k = k - 1) begin
                    if (en[k])
                        next_slot = k[3:0];
                end
            end
        end
    endfunction

    reg [31:0] mode_reg;
    reg [31:0] config_reg;
    reg [23:0] result;
    reg [3:0] result_ind;
    reg gain_err;
    reg [`ACSR_IRQ_BITS-1:0] irq_status;
    reg [`ACSR_IRQ_BITS-1:0] irq_mask;
    reg [3:0] slot;

    wire [9:0] enables = {config_reg[`ACSR_CFG_SHORT], config_reg[`ACSR_CFG_TEMP],
                          config_reg[`ACSR_CFG_CH_MSB:`ACSR_CFG_CH_LSB]};
    wire pseudo = config_reg[`ACSR_CFG_PSEUDO];
    wire append = mode_reg[`ACSR_MODE_APPEND];
    wire [2:0] gain_code = config_reg[`ACSR_CFG_GAIN_MSB:`ACSR_CFG_GAIN_LSB];
    wire [7:0] status_byte = {rdy_n, gain_err, 2'b00, result_ind};

    // Wishbone decode
    // Ack low gates the take, so one request gives exactly one ack
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [2:0] reg_idx = wb_adr_i[4:2];
    wire wr_mode = wb_req && wb_we_i && (reg_idx == `ACSR_IDX_MODE);
    wire wr_config = wb_req && wb_we_i && (reg_idx == `ACSR_IDX_CONFIG);
    wire wr_mask = wb_req && wb_we_i && (reg_idx == `ACSR_IDX_IRQ_MASK);
    wire rd_result = wb_req && !wb_we_i && (reg_idx == `ACSR_IDX_RESULT);
    wire rd_irq = wb_req && !wb_we_i && (reg_idx == `ACSR_IDX_IRQ_STATUS);
    // Config as it will stand after this write; the sequencer restarts from it
    wire [31:0] cfg_merged = merge_sel(config_reg, wb_dat_i, wb_sel_i);

    // Serial pin synchronisers
    reg sclk_s1, sclk_s2, sclk_d;
    reg cs_s1, cs_s2, cs_d;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sclk_d <= 1'b1;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_d <= 1'b1;
        end else begin
            sclk_s1 <= ser_clk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            cs_s1 <= ser_cs_n;
            cs_s2 <= cs_s1;
            cs_d <= cs_s2;
        end
    end
    wire sclk_rise = sclk_s2 && !sclk_d;
    wire sclk_fall = !sclk_s2 && sclk_d;
    wire cs_fall = !cs_s2 && cs_d;
    wire cs_active = !cs_s2;

    // Serial readout of result, optionally followed by status
    reg [31:0] shift;
    reg [5:0] bits_left;
    reg ser_busy;
    reg ser_done;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift <= 32'h00000000;
            bits_left <= 6'h00;
            ser_busy <= 1'b0;
            ser_done <= 1'b0;
            ser_dout <= 1'b0;
        end else begin
            ser_done <= 1'b0;
            if (!cs_active) begin
                ser_busy <= 1'b0;
            end else if (cs_fall) begin
                // Snapshot at select so a new result cannot tear the frame
                shift <= {result, status_byte};
                bits_left <= append ? 6'h20 : 6'h18;
                ser_busy <= 1'b1;
                ser_dout <= result[23];
            end else if (ser_busy) begin
                // First fall re-drives the MSB; the host samples on each rise
                if (sclk_fall) begin
                    shift <= {shift[30:0], 1'b0};
                    ser_dout <= shift[31];
                end
                if (sclk_rise) begin
                    bits_left <= bits_left - 6'h01;
                    if (bits_left == 6'h01) begin
                        ser_busy <= 1'b0;
                        ser_done <= 1'b1;
                    end
                end
            end
        end
    end

    // Channel sequencer and result capture
    wire [3:0] dec_ind, dec_pos, dec_neg;
    wire [2:0] dec_pair;
    wire dec_pair_valid;
    acsr_chan_decode u_dec (
        .slot(slot),
        .pseudo(pseudo),
        .indicator(dec_ind),
        .pos_in(dec_pos),
        .neg_in(dec_neg),
        .cal_pair(dec_pair),
        .cal_pair_valid(dec_pair_valid)
    );

    wire take_result = conv_valid && (enables != 10'h000);
    wire read_done = ser_done || rd_result;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slot <= 4'h0;
            result <= `ACSR_RESULT_RESET;
            result_ind <= 4'h0;
            rdy_n <= 1'b1;
        end else begin
            // A config write restarts the scan at the lowest enabled slot
            if (wr_config) begin
                slot <= next_slot(cfg_merged[9:0], 4'hF);
            end else if (take_result) begin
                slot <= next_slot(enables, slot);
            end
            if (take_result) begin
                result <= conv_data;
                result_ind <= dec_ind;
            end
            // New result wins over a read finishing in the same cycle
            if (take_result)
                rdy_n <= 1'b0;
            else if (read_done)
                rdy_n <= 1'b1;
        end
    end

    // Registered front-end selection
    // A slot change shows one cycle later on the mux and pair fields; channel_indicator follows result_ind, the slot of the last result
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ain_pos <= `ACSR_IN_NONE;
            ain_neg <= `ACSR_IN_NONE;
            cal_pair <= 3'h0;
            cal_pair_valid <= 1'b0;
            channel_indicator <= 4'h0;
        end else begin
            ain_pos <= dec_pos;
            ain_neg <= dec_neg;
            cal_pair <= dec_pair;
            cal_pair_valid <= dec_pair_valid;
            channel_indicator <= result_ind;
        end
    end

    // Gain decode; reserved codes keep the last valid gain
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gain_log2 <= 3'h0;
            gain_err <= 1'b0;
        end else begin
            // Valid codes equal log2 of the gain, so the code passes straight through
            case (gain_code)
                `ACSR_GAIN_R1, `ACSR_GAIN_R2: begin
                    gain_err <= 1'b1;
                end
                default: begin
                    gain_err <= 1'b0;
                    gain_log2 <= gain_code;
                end
            endcase
        end
    end

    // Control registers, interrupts and bus answer
    wire [`ACSR_IRQ_BITS-1:0] irq_events = {ser_done, take_result};
    reg [31:0] rd_data;
    always @* begin
        rd_data = 32'h00000000;
        case (reg_idx)
            `ACSR_IDX_STATUS: rd_data = {24'h000000, status_byte};
            `ACSR_IDX_MODE: rd_data = mode_reg;
            `ACSR_IDX_CONFIG: rd_data = config_reg;
            `ACSR_IDX_RESULT: rd_data = append ? {status_byte, result} : {8'h00, result};
            `ACSR_IDX_IDENT: rd_data = {24'h000000, ID_VALUE};
            `ACSR_IDX_IRQ_STATUS: rd_data = {30'h00000000, irq_status};
            `ACSR_IDX_IRQ_MASK: rd_data = {30'h00000000, irq_mask};
            default: rd_data = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= 32'h00000000;
            config_reg <= `ACSR_CFG_RESET;
            irq_status <= {`ACSR_IRQ_BITS{1'b0}};
            irq_mask <= {`ACSR_IRQ_BITS{1'b0}};
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            irq <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req)
                wb_dat_o <= wb_we_i ? 32'h00000000 : rd_data;
            if (wr_mode)
                mode_reg <= merge_sel(mode_reg, wb_dat_i, wb_sel_i) & 32'h00000001;
            if (wr_config)
                config_reg <= cfg_merged & 32'h000077FF;
            if (wr_mask)
                irq_mask <= wb_dat_i[`ACSR_IRQ_BITS-1:0] & {`ACSR_IRQ_BITS{wb_sel_i[0]}};
            // Event in the clearing cycle stays set
            if (rd_irq)
                irq_status <= irq_events;
            else
                irq_status <= irq_status | irq_events;
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule // acsr_top

`default_nettype wire

//--- testbench/acsr_chk.sv
// Port-level checker for the channel select and readout block.
// Assumes full-lane register writes and an enabled slot for every word sent.
`timescale 1ns/1ps
`default_nettype none
module acsr_chk #(
    parameter [7:0] ID_VALUE = 8'h00 // Arbitrary value
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic conv_valid,
    input wire logic [23:0] conv_data,
    input wire logic rdy_n,
    input wire logic [3:0] ain_pos,
    input wire logic [3:0] ain_neg,
    input wire logic [2:0] cal_pair,
    input wire logic cal_pair_valid,
    input wire logic [3:0] channel_indicator,
    input wire logic [2:0] gain_log2
);
    wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [2:0] idx = wb_adr_i[4:2];
    wire res_rd = tk && !wb_we_i && idx == 3'h3 && !conv_valid;
    wire cfg_wr = tk && wb_we_i && idx == 3'h2;
    wire rsv = wb_dat_i[14:12] == 3'h1 || wb_dat_i[14:12] == 3'h2;
    logic [23:0] word;
    logic app;
    // Shadow of the last word and append control, so writes to the result cannot hide
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word <= 24'h000000;
            app <= 1'b0;
        end else begin
            word <= conv_valid ? conv_data : word;
            app <= (tk && wb_we_i && idx == 3'h1) ? wb_dat_i[0] : app;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_ident; tk && !wb_we_i && idx == 3'h4 |=> wb_dat_o[7:0] == ID_VALUE; endproperty
    a_ident: assert property (p_ident) else $error("ident value wrong");
    property p_data; res_rd |=> wb_dat_o[23:0] == word; endproperty
    a_data: assert property (p_data) else $error("result data wrong");
    property p_rd_rdy; res_rd |=> rdy_n; endproperty
    a_rd_rdy: assert property (p_rd_rdy) else $error("ready not cleared by read");
    property p_conv_rdy; conv_valid |=> !rdy_n; endproperty
    a_conv_rdy: assert property (p_conv_rdy) else $error("ready not set by word");
    property p_append; res_rd |=> (app ? wb_dat_o[27:24] == channel_indicator
        : wb_dat_o[31:24] == 8'h00); endproperty
    a_append: assert property (p_append) else $error("appended status wrong");
    property p_gain; cfg_wr && !rsv |-> ##2 gain_log2 == $past(wb_dat_i[14:12], 2); endproperty
    a_gain: assert property (p_gain) else $error("gain not applied");
    property p_gain_rsv; cfg_wr && rsv |-> ##2 gain_log2 == $past(gain_log2, 2); endproperty
    a_gain_rsv: assert property (p_gain_rsv) else $error("reserved gain applied");
    property p_diff; cal_pair_valid && ain_neg != 4'h0 |-> ((ain_pos == ain_neg)
        ? (ain_pos == 4'h2 && cal_pair == 3'h0)
        : (ain_neg == ain_pos + 4'h1 && ain_pos[0] && cal_pair == ain_pos[3:1])); endproperty
    a_diff: assert property (p_diff) else $error("differential decode wrong");
    property p_pseudo; cal_pair_valid && ain_neg == 4'h0 |-> cal_pair == ((ain_pos == 4'h0)
        ? 3'h0 : ((ain_pos > 4'h4) ? 3'h4 : ain_pos[2:0] - 3'h1)); endproperty
    a_pseudo: assert property (p_pseudo) else $error("pseudo decode wrong");
endmodule // acsr_chk
bind acsr_top acsr_chk #(.ID_VALUE(ID_VALUE)) acsr_chk_i (.clk, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_valid, .conv_data, .rdy_n,
    .ain_pos, .ain_neg, .cal_pair, .cal_pair_valid, .channel_indicator, .gain_log2);
`default_nettype wire

//--- testbench/acsr_host.sv
// Host side of the serial readout: frames one read and collects the bits.
// Assumes the block shifts on falling serial clock; clock idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module acsr_host (
    output logic ser_clk = 1'b1,
    output logic ser_cs_n = 1'b1,
    input wire logic ser_dout
);
    task automatic read_frame(input int nbits, output logic [31:0] word);
        word = 32'h00000000;
        #37 ser_cs_n = 1'b0;
        // Select is synchronised inside, so give it time before clocking
        #800;
        repeat (nbits) begin
            ser_clk = 1'b0;
            #400 ser_clk = 1'b1;
            word = {word[30:0], ser_dout};
            #400;
        end
        ser_cs_n = 1'b1;
    endtask
endmodule // acsr_host
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the channel select and readout block.
// Assumes the bound checker and the serial host model acsr_host.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, ser_clk, ser_cs_n, ser_dout, wb_ack_o, rdy_n, irq, cal_pair_valid;
    logic arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, conv_valid = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'hF, ain_pos, ain_neg, channel_indicator;
    logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, q, w;
    logic [23:0] conv_data = 24'h000000;
    logic [2:0] cal_pair, gain_log2, g, eg = 3'h0;
    int num_errors = 0, checks = 0, cycles = 0, s;
    // Pos, neg, pair valid, pair: differential slots 0..9, then pseudo
    logic [11:0] rows [20] = '{12'h128, 12'h349, 12'h56A, 12'h78B, 12'h128, 12'h349, 12'h56A,
        12'h78B, 12'hE00, 12'h228, 12'h108, 12'h209, 12'h30A, 12'h40B, 12'h50C, 12'h60C,
        12'h70C, 12'h80C, 12'hE00, 12'h008};
    logic [3:0] seq [5] = '{4'h0, 4'h5, 4'h8, 4'h9, 4'h0};
    acsr_top #(.ID_VALUE(8'h3C)) acsr_top_i (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_valid, .conv_data, .ser_clk,
        .ser_cs_n, .ser_dout, .rdy_n, .irq, .ain_pos, .ain_neg, .cal_pair, .cal_pair_valid,
        .channel_indicator, .gain_log2);
    acsr_host acsr_host_i (.ser_clk, .ser_cs_n, .ser_dout);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [2:0] idx, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= d;
        // A hang here is cut by the cycle ceiling
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic conv(input logic [23:0] word);
        @(posedge clk);
        conv_valid <= 1'b1;
        conv_data <= word;
        @(posedge clk);
        conv_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        chk({31'h0, rdy_n}, 32'h1);
        arst_n <= 1'b1;
        wb(1'b0, 3'h3, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 3'h4, 32'hFFFFFFFF);
        wb(1'b0, 3'h4, 32'h0);
        chk(q & 32'hFF, 32'h3C);
        wb(1'b0, 3'h7, 32'h0);
        chk(q, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 20; i++) begin
            s = i % 10;
            g = i[2:0];
            if (g != 3'h1 && g != 3'h2)
                eg = g;
            wb(1'b1, 3'h2, {17'h0, g, 1'b0, i >= 10, 10'h0} | (32'h1 << s));
            repeat (2) @(posedge clk);
            chk({20'h0, {ain_pos, ain_neg, cal_pair_valid, cal_pair}
                & (s == 8 ? 12'hF08 : 12'hFFF)}, {20'h0, rows[i]});
            chk({29'h0, gain_log2}, {29'h0, eg});
            conv({19'h61A2C, i[4:0]});
            wb(1'b0, 3'h0, 32'h0);
            chk(q & 32'hCF, {25'h0, (g == 3'h1 || g == 3'h2), 2'h0, s[3:0]});
            wb(1'b0, 3'h3, 32'h0);
            chk(q, {8'h00, 19'h61A2C, i[4:0]});
            $display("row %0d done", i);
        end
        wb(1'b1, 3'h1, 32'h1);
        wb(1'b1, 3'h6, 32'h1);
        wb(1'b0, 3'h5, 32'h0);
        wb(1'b1, 3'h2, 32'h321);
        for (int k = 0; k < 5; k++) begin
            conv({20'hABCDE, k[3:0]});
            chk({31'h0, irq}, 32'h1);
            wb(1'b0, 3'h5, 32'h0);
            chk(q & 32'h1, 32'h1);
            wb(1'b0, 3'h3, 32'h0);
            chk(q & 32'h0FFFFFFF, {4'h0, seq[k], 20'hABCDE, k[3:0]});
            chk({31'h0, irq}, 32'h0);
        end
        $display("sequence test done");
        wb(1'b1, 3'h6, 32'h0);
        conv(24'h5A5A5A);
        chk({31'h0, irq}, 32'h0);
        acsr_host_i.read_frame(32, w);
        repeat (6) @(posedge clk);
        chk(w & 32'hFFFFFFCF, 32'h5A5A5A05);
        chk({31'h0, rdy_n}, 32'h1);
        wb(1'b0, 3'h5, 32'h0);
        chk(q & 32'h3, 32'h3);
        wb(1'b1, 3'h3, 32'hFFFFFFFF);
        wb(1'b0, 3'h3, 32'h0);
        chk(q & 32'hFFFFFF, 32'h5A5A5A);
        $display("serial test done");
        conv(24'hC3A5F0);
        acsr_host_i.read_frame(8, w);
        repeat (6) @(posedge clk);
        chk(w, 32'h000000C3);
        chk({31'h0, rdy_n}, 32'h0);
        wb(1'b0, 3'h5, 32'h0);
        chk(q & 32'h3, 32'h1);
        $display("abort test done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, rdy_n}, 32'h1);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({20'h0, ain_pos, ain_neg, cal_pair_valid, cal_pair}, 32'h128);
        wb(1'b0, 3'h3, 32'h0);
        chk(q, 32'h0);
        $display("reset again done");
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
